// ### common/csf_pkg.sv
/*
  Constants and types for the charger supervisory controller.
  Assumes a 200 MHz system clock; all times are converted to cycle counts here.
*/
package csf_pkg;
  localparam int CLK_MHZ = 200;
  // fault pulse on the status pin, in microseconds
  localparam int FAULT_PULSE_US = 128;
  localparam int FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
  // battery detection period and retry delay, in microseconds (plain defaults)
  localparam int DETECT_US = 250;
  localparam int DETECT_CYC = DETECT_US * CLK_MHZ;
  localparam int RETRY_US = 1000;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int CNT_W = 32;
  // cycles the pin synchronisers need before the boot decision may read them
  localparam int BOOT_WAIT_CYC = 2;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  // control register fields
  localparam int CTRL_CHG_DIS = 0;
  localparam int CTRL_ILIM_HI = 1;
  localparam int CTRL_ILIM_OFF = 2;
  localparam int CTRL_TERM_EN = 3;
  localparam int CTRL_HOST_PROG = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [4:0] CTRL_MASK = 5'h1F;
  // status register fields
  localparam int STAT_VIN_OV = 0;
  localparam int STAT_BAT_OV = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_NOBAT = 3;
  localparam int STAT_STATE = 8;

  typedef enum logic [3:0] {
    CSF_BOOT,
    CSF_CHARGE,
    CSF_SLEEP,
    CSF_RETRY,
    CSF_DETECT,
    CSF_DONE,
    CSF_FAULT,
    CSF_HOT
  } csf_state_type;
endpackage

// ### rtl/csf_supervisor.sv
/*
  Charge-mode supervisory controller with an APB register slave.
  Assumes analog comparators deliver asynchronous level flags that are synchronised here,
  and that the host keeps long counts short in simulation via the top parameters.
*/
// Overview of operation
// - at reset, battery above weak threshold: keep register-selected operating mode
// - weak battery, unsupervised: reload register defaults, charge, limit from pin
// - weak unsupervised boot: low limit while pin low, high limit while pin high
// - termination disabled by default so charging continues at regulation
// - weak battery but host supervised: keep register mode, no default reload
// - two input limits; reduce charge current when input reaches the limit
// - host can disable input limiting; host clears it only if source suffices
// - at regulation temperature taper charge current, zero about ten degrees higher
// - over shutdown temperature: stop PWM, suspend charge, freeze timers until cool
// - sleep from charge state when supply below battery plus offset yet above poor-source level
// - poor source while charging: abort, wait retry delay, restart charging
// - supply overvoltage: stop PWM, flag fault, pulse pin; resume on exit
// - battery overvoltage: stop PWM, flag fault, pulse pin; clear on exit
// - supervised, above recharge and termination current: stop, discharge, then sample
// - sampled battery still above recharge: battery present, report done
// - sampled below recharge: battery absent, reload defaults, resume after retry
// - no battery: short-circuit mode below short threshold, PWM mode above
// - without battery hold regulation until long timer expires or host takes over
// - battery below short threshold while charging: short-circuit current only
// - supervised while host services the timer, unsupervised otherwise
// - each fault notification starts one fixed low pulse, restarting any pulse in progress, then high impedance
`timescale 1ns/1ps
`default_nettype none
module csf_supervisor #(
  parameter int RETRY_CYCLES = csf_pkg::RETRY_CYC,
  parameter int DETECT_CYCLES = csf_pkg::DETECT_CYC,
  parameter int PULSE_CYCLES = csf_pkg::FAULT_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic otg_pin_i,
  input wire logic bat_above_weak_i,
  input wire logic host_supervised_i,
  input wire logic vin_lt_sleep_i,
  input wire logic vin_le_poor_i,
  input wire logic vin_ov_i,
  input wire logic bat_ov_i,
  input wire logic bat_above_recharge_i,
  input wire logic term_current_i,
  input wire logic bat_below_short_i,
  input wire logic at_regulation_i,
  input wire logic long_timer_expired_i,
  input wire logic die_at_reg_i,
  input wire logic die_shutdown_i,
  input wire logic die_cooled_i,
  input wire logic input_at_limit_i,
  output logic pwm_en_o,
  output logic blocking_switch_on_o,
  output logic short_mode_o,
  output logic ilim_high_o,
  output logic ilim_enable_o,
  output logic chg_reduce_o,
  output logic chg_taper_o,
  output logic detect_discharge_o,
  output logic timers_freeze_o,
  output logic hold_regulation_o,
  output logic stat_o,
  output logic stat_oe_o
);
  import csf_pkg::*;

  localparam int NSYNC = 16;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    csf_state_type st;
    csf_state_type ret;
    logic [4:0] ctrl;
    logic defaults_mode;
    logic vin_ov_f;
    logic bat_ov_f;
    logic done_f;
    logic nobat_f;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] pcnt;
    logic [31:0] rdata;
  } csf_regs_type;

  csf_regs_type q, d;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sy;
  logic wr_en, rd_en, ctrl_hit, stat_hit, fault_evt;

  assign raw = {input_at_limit_i, die_cooled_i, die_shutdown_i, die_at_reg_i,
                long_timer_expired_i, at_regulation_i, bat_below_short_i, term_current_i,
                bat_above_recharge_i, bat_ov_i, vin_ov_i, vin_le_poor_i,
                vin_lt_sleep_i, host_supervised_i, bat_above_weak_i, otg_pin_i};
  assign sy = q.s2;

  wire otg = sy[0];
  wire weak_ok = sy[1];
  wire sup = sy[2];
  wire slp = sy[3];
  wire poor = sy[4];
  wire vov = sy[5];
  wire bov = sy[6];
  wire rch = sy[7];
  wire term = sy[8];
  wire shrt = sy[9];
  wire atreg = sy[10];
  wire ltexp = sy[11];
  wire dreg = sy[12];
  wire dhot = sy[13];
  wire dcool = sy[14];
  wire inlim = sy[15];

  assign ctrl_hit = paddr_i == CTRL_OFS;
  assign stat_hit = paddr_i == STAT_OFS;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !(ctrl_hit || stat_hit);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    fault_evt = 1'b0;
    if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (q.pcnt != '0) begin
      d.pcnt = q.pcnt - 1'b1;
    end
    // register writes; host programming ends the default-reload period
    if (wr_en && ctrl_hit) begin
      d.ctrl = pwdata_i[4:0] & CTRL_MASK;
      d.defaults_mode = 1'b0;
    end
    if (wr_en && stat_hit) begin
      d.done_f = q.done_f & ~pwdata_i[STAT_DONE];
      d.nobat_f = q.nobat_f & ~pwdata_i[STAT_NOBAT];
    end
    unique case (q.st)
      CSF_BOOT: begin
        // synchronisers are cleared by reset; wait until they hold real levels
        if (q.cnt == '0) begin
          if (!weak_ok && !sup) begin
            d.ctrl = CTRL_RESET[4:0];
            d.defaults_mode = 1'b1;
          end
          d.st = CSF_CHARGE;
        end
      end
      CSF_CHARGE: begin
        if (poor) begin
          d.cnt = CNT_W'(RETRY_CYCLES);
          d.st = CSF_RETRY;
          fault_evt = 1'b1;
        end else if (slp) begin
          d.st = CSF_SLEEP;
          fault_evt = 1'b1;
        end else if (sup && !q.defaults_mode && q.ctrl[CTRL_TERM_EN] && rch && term) begin
          d.cnt = CNT_W'(DETECT_CYCLES);
          d.st = CSF_DETECT;
        end
      end
      CSF_SLEEP: begin
        if (poor) begin
          d.cnt = CNT_W'(RETRY_CYCLES);
          d.st = CSF_RETRY;
          fault_evt = 1'b1;
        end else if (!slp) begin
          d.st = CSF_CHARGE;
        end
      end
      CSF_RETRY: begin
        if (q.cnt == '0) begin
          d.st = CSF_CHARGE;
        end
      end
      CSF_DETECT: begin
        if (q.cnt == '0) begin
          if (rch) begin
            d.done_f = 1'b1;
            d.st = CSF_DONE;
          end else begin
            d.nobat_f = 1'b1;
            d.ctrl = CTRL_RESET[4:0];
            d.cnt = CNT_W'(RETRY_CYCLES);
            d.st = CSF_RETRY;
            fault_evt = 1'b1;
          end
        end
      end
      CSF_DONE: begin
        if (!rch) begin
          d.st = CSF_CHARGE;
        end
      end
      CSF_FAULT: begin
        if (!vov && !bov) begin
          d.vin_ov_f = 1'b0;
          d.bat_ov_f = 1'b0;
          d.st = q.ret;
        end
      end
      CSF_HOT: begin
        if (dcool) begin
          d.st = q.ret;
        end
      end
      default: begin
        d.st = CSF_BOOT;
      end
    endcase
    // thermal shutdown from any state except boot, delay counter cnt frozen
    if (dhot && q.st != CSF_HOT && q.st != CSF_BOOT) begin
      d.ret = (q.st == CSF_FAULT) ? q.ret : q.st;
      d.st = CSF_HOT;
      d.cnt = q.cnt;
      fault_evt = 1'b1;
    end else if ((vov || bov) && q.st != CSF_FAULT && q.st != CSF_HOT && q.st != CSF_BOOT) begin
      d.ret = (q.st == CSF_DETECT) ? CSF_CHARGE : q.st;
      d.st = CSF_FAULT;
      d.vin_ov_f = vov;
      d.bat_ov_f = bov;
      fault_evt = 1'b1;
    end
    if (q.st == CSF_HOT) begin
      d.cnt = q.cnt;
    end
    // each notification starts one fixed low pulse, restarting one in progress
    if (fault_evt) begin
      d.pcnt = CNT_W'(PULSE_CYCLES);
    end
    d.rdata = 32'h0000_0000;
    if (rd_en && ctrl_hit) begin
      d.rdata = {27'h0, q.ctrl};
    end else if (rd_en && stat_hit) begin
      d.rdata = {20'h0, 4'(q.st), 4'h0, q.nobat_f, q.done_f, q.bat_ov_f, q.vin_ov_f};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{s1: '0, s2: '0, st: CSF_BOOT, ret: CSF_CHARGE, ctrl: CTRL_RESET[4:0],
             defaults_mode: 1'b0, vin_ov_f: 1'b0, bat_ov_f: 1'b0, done_f: 1'b0,
             nobat_f: 1'b0, cnt: CNT_W'(BOOT_WAIT_CYC), pcnt: '0, rdata: '0};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire charging = (q.st == CSF_CHARGE) && !q.ctrl[CTRL_CHG_DIS];
  assign prdata_o = q.rdata;
  // sleep turns off the switch and PWM
  assign blocking_switch_on_o = q.st != CSF_SLEEP && q.st != CSF_HOT && q.st != CSF_BOOT;
  assign short_mode_o = charging && shrt;
  assign pwm_en_o = charging && !shrt;
  // default-mode limit follows the pin; register selection otherwise
  assign ilim_high_o = q.defaults_mode ? otg : q.ctrl[CTRL_ILIM_HI];
  assign ilim_enable_o = q.defaults_mode || !q.ctrl[CTRL_ILIM_OFF];
  // charge current backs off at the input limit
  assign chg_reduce_o = charging && ilim_enable_o && inlim;
  assign chg_taper_o = charging && dreg;
  assign detect_discharge_o = q.st == CSF_DETECT;
  assign timers_freeze_o = q.st == CSF_HOT;
  // hold regulation in default mode until long timer or host
  assign hold_regulation_o = charging && q.defaults_mode && atreg && !ltexp;
  assign stat_o = 1'b0;
  assign stat_oe_o = q.pcnt != '0;

  AST_PULSE_LEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(stat_oe_o) |-> stat_oe_o [*8])
    else $error("fault pulse too short");
  AST_HOT_STOP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_HOT |-> !pwm_en_o && !short_mode_o && $stable(q.cnt))
    else $error("thermal shutdown not holding");
  AST_SLEEP_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_SLEEP |-> !blocking_switch_on_o && !pwm_en_o)
    else $error("sleep left switch on");
  AST_POOR_RETRY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_CHARGE && poor && !dhot && !vov && !bov |=> q.st == CSF_RETRY)
    else $error("poor source not aborted");
  AST_OV_FAULT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_CHARGE && vov && !dhot |=> q.st == CSF_FAULT && q.vin_ov_f && stat_oe_o)
    else $error("supply overvoltage not flagged");
  AST_BOV_FAULT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_FAULT |-> !pwm_en_o && !short_mode_o)
    else $error("pwm on during fault");
  AST_DONE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_DETECT && q.cnt == '0 && rch && !dhot && !vov && !bov
      |=> q.st == CSF_DONE && q.done_f)
    else $error("present battery not reported");
  AST_NOBAT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_DETECT && q.cnt == '0 && !rch && !dhot && !vov && !bov
      |=> q.st == CSF_RETRY && q.ctrl == CTRL_RESET[4:0])
    else $error("absent battery not handled");
  AST_ILIM_PIN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.defaults_mode |-> ilim_high_o == otg && ilim_enable_o)
    else $error("boot limit not from pin");
  AST_SHORT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    charging && shrt |-> short_mode_o && !pwm_en_o)
    else $error("short mode missing");
  AST_BOOT_WAIT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_BOOT && q.cnt != '0 |=> q.st == CSF_BOOT)
    else $error("boot decided before synchronisers filled");
  AST_BOOT_DEFAULTS: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_BOOT && q.cnt == '0 && !weak_ok && !sup
      |=> q.defaults_mode && q.ctrl == CTRL_RESET[4:0] && q.st == CSF_CHARGE)
    else $error("unsupervised weak boot did not load defaults");
  AST_BOOT_KEEP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_BOOT && q.cnt == '0 && (weak_ok || sup) |=> !q.defaults_mode)
    else $error("register mode not kept at boot");
  AST_DETECT_DISCH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_CHARGE && sup && !q.defaults_mode && q.ctrl[CTRL_TERM_EN] && rch && term
      && !poor && !slp && !dhot && !vov && !bov |=> detect_discharge_o && !pwm_en_o)
    else $error("battery detection not started");
  AST_RETRY_LEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_RETRY && q.cnt != '0 && !dhot && !vov && !bov |=> q.st == CSF_RETRY)
    else $error("retry delay cut short");
  AST_VOV_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_FAULT && !vov && !bov && !dhot
      |=> !q.vin_ov_f && !q.bat_ov_f && q.st != CSF_FAULT)
    else $error("overvoltage fault not cleared on exit");
  AST_HOT_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    dhot && !dcool && q.st != CSF_BOOT |=> q.st == CSF_HOT && timers_freeze_o)
    else $error("thermal shutdown not entered");
  AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_CHARGE && slp && !poor && !dhot && !vov && !bov |=> q.st == CSF_SLEEP)
    else $error("sleep not entered");
  AST_PULSE_END: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stat_oe_o && q.pcnt == CNT_W'(1) && !fault_evt |=> !stat_oe_o)
    else $error("fault pulse did not end");
  AST_STAT_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stat_oe_o |-> !stat_o)
    else $error("status pin driven high");
  AST_ILIM_REG: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !q.defaults_mode |-> ilim_high_o == q.ctrl[CTRL_ILIM_HI])
    else $error("limit not from register");
  AST_ILIM_OFF: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !q.defaults_mode && q.ctrl[CTRL_ILIM_OFF] |-> !ilim_enable_o && !chg_reduce_o)
    else $error("limiting not disabled");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    hold_regulation_o |-> q.defaults_mode && atreg && !ltexp)
    else $error("regulation hold outside default mode");
  AST_DONE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    q.st == CSF_DONE && rch && !dhot && !vov && !bov |=> q.st == CSF_DONE)
    else $error("charge done left early");
endmodule
`default_nettype wire

// ### tb/csf_source_model.sv
/*
  Behavioural supply and battery model that turns millivolt levels into comparator flags.
  Assumes the bench sets both levels right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module csf_source_model #(
  parameter int WEAK_MV = 3400,
  parameter int SHORT_MV = 2000,
  parameter int RCH_MV = 3440,
  parameter int SLP_OFS_MV = 100,
  parameter int POOR_MV = 2800,
  parameter int VIN_OV_MV = 6500,
  parameter int BAT_OV_MV = 4600
) (
  input wire logic [15:0] vin_mv_i,
  input wire logic [15:0] bat_mv_i,
  output logic bat_above_weak_o,
  output logic vin_lt_sleep_o,
  output logic vin_le_poor_o,
  output logic vin_ov_o,
  output logic bat_ov_o,
  output logic bat_above_recharge_o,
  output logic bat_below_short_o
);
  assign bat_above_weak_o = int'(bat_mv_i) > WEAK_MV;
  assign vin_lt_sleep_o = int'(vin_mv_i) < int'(bat_mv_i) + SLP_OFS_MV
    && int'(vin_mv_i) > POOR_MV;
  assign vin_le_poor_o = int'(vin_mv_i) <= POOR_MV;
  assign vin_ov_o = int'(vin_mv_i) > VIN_OV_MV;
  assign bat_ov_o = int'(bat_mv_i) > BAT_OV_MV;
  assign bat_above_recharge_o = int'(bat_mv_i) > RCH_MV;
  assign bat_below_short_o = int'(bat_mv_i) < SHORT_MV;
endmodule
`default_nettype wire

// ### tb/testbench.sv
/*
  Self-checking bench for the charger supervisor, acting as APB host.
  Assumes the source model feeds the comparator flags and short sim counts.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csf_pkg::*;
  logic clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic pready_o, pslverr_o, otg_pin_i = 0, host_supervised_i = 0;
  logic term_current_i = 0, at_regulation_i = 0, long_timer_expired_i = 0;
  logic die_at_reg_i = 0, die_shutdown_i = 0, die_cooled_i = 0, input_at_limit_i = 0;
  logic bat_above_weak_i, vin_lt_sleep_i, vin_le_poor_i, vin_ov_i, bat_ov_i;
  logic bat_above_recharge_i, bat_below_short_i, err;
  logic pwm_en_o, blocking_switch_on_o, short_mode_o, ilim_high_o, ilim_enable_o;
  logic chg_reduce_o, chg_taper_o, detect_discharge_o, timers_freeze_o;
  logic hold_regulation_o, stat_o, stat_oe_o;
  logic [15:0] vin_mv = 16'd5000, bat_mv = 16'd3000;
  int fail_count = 0, check_count = 0, n;
  always #2.5 clk_i = ~clk_i;
  csf_supervisor #(.RETRY_CYCLES(20), .DETECT_CYCLES(10), .PULSE_CYCLES(16))
    csf_supervisor_inst (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .otg_pin_i, .bat_above_weak_i,
    .host_supervised_i, .vin_lt_sleep_i, .vin_le_poor_i, .vin_ov_i, .bat_ov_i,
    .bat_above_recharge_i, .term_current_i, .bat_below_short_i, .at_regulation_i,
    .long_timer_expired_i, .die_at_reg_i, .die_shutdown_i, .die_cooled_i,
    .input_at_limit_i, .pwm_en_o, .blocking_switch_on_o, .short_mode_o, .ilim_high_o,
    .ilim_enable_o, .chg_reduce_o, .chg_taper_o, .detect_discharge_o, .timers_freeze_o,
    .hold_regulation_o, .stat_o, .stat_oe_o);
  csf_source_model csf_source_model_inst (.vin_mv_i(vin_mv), .bat_mv_i(bat_mv),
    .bat_above_weak_o(bat_above_weak_i), .vin_lt_sleep_o(vin_lt_sleep_i),
    .vin_le_poor_o(vin_le_poor_i), .vin_ov_o(vin_ov_i), .bat_ov_o(bat_ov_i),
    .bat_above_recharge_o(bat_above_recharge_i), .bat_below_short_o(bat_below_short_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  // settle point after n edges, away from the sampling edge
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task automatic state_is(input logic [3:0] s);
    apb(0, STAT_OFS, 0);
    chk(rd[11:8], s);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hEBA49523));
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1;
    wt(8);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      otg_pin_i <= 1'($urandom);
      wt(6);
      chk(ilim_enable_o, 1);
      chk(ilim_high_o, otg_pin_i);
      chk(pwm_en_o, 1);
    end
    @(posedge clk_i);
    input_at_limit_i <= 1;
    die_at_reg_i <= 1;
    at_regulation_i <= 1;
    wt(4);
    chk(chg_reduce_o, 1);
    chk(chg_taper_o, 1);
    chk(hold_regulation_o, 1);
    @(posedge clk_i);
    long_timer_expired_i <= 1;
    wt(4);
    chk(hold_regulation_o, 0);
    apb(0, CTRL_OFS, 0);
    chk(rd, CTRL_RESET);
    apb(0, 8'h08, 0);
    chk(err, 1);
    chk(rd, 0);
    @(posedge clk_i);
    vin_mv <= 16'd7000;
    n = 0;
    repeat (40) begin
      @(negedge clk_i);
      n += int'(stat_oe_o === 1'b1 && stat_o === 1'b0);
    end
    chk(n, 16);
    chk(pwm_en_o, 0);
    apb(0, STAT_OFS, 0);
    chk(rd[STAT_VIN_OV], 1);
    @(posedge clk_i);
    vin_mv <= 16'd5000;
    wt(8);
    chk(pwm_en_o, 1);
    @(posedge clk_i);
    die_shutdown_i <= 1;
    wt(6);
    chk({pwm_en_o, timers_freeze_o}, 2'b01);
    @(posedge clk_i);
    die_shutdown_i <= 0;
    die_cooled_i <= 1;
    wt(8);
    chk({pwm_en_o, timers_freeze_o}, 2'b10);
    @(posedge clk_i);
    vin_mv <= 16'd2900;
    wt(6);
    chk({blocking_switch_on_o, pwm_en_o}, 2'b00);
    @(posedge clk_i);
    vin_mv <= 16'd2700;
    wt(6);
    state_is(4'd3);
    @(posedge clk_i);
    vin_mv <= 16'd5000;
    n = 0;
    do begin
      apb(0, STAT_OFS, 0);
      n++;
    end while (rd[11:8] !== 4'd1 && n < 40);
    chk(rd[11:8], 4'd1);
    @(posedge clk_i);
    bat_mv <= 16'd1500;
    wt(6);
    chk(short_mode_o, 1);
    apb(1, CTRL_OFS, 32'h4);
    wt(3);
    chk(ilim_enable_o, 0);
    chk(chg_reduce_o, 0);
    apb(1, CTRL_OFS, 32'h2);
    wt(3);
    chk({ilim_enable_o, ilim_high_o}, 2'b11);
    chk(chg_reduce_o, 1);
    // termination with a battery that stays, then with one that is gone
    @(posedge clk_i);
    host_supervised_i <= 1;
    apb(1, CTRL_OFS, 32'hA);
    @(posedge clk_i);
    bat_mv <= 16'd3600;
    term_current_i <= 1;
    wt(6);
    chk({detect_discharge_o, pwm_en_o}, 2'b10);
    wt(12);
    state_is(4'd5);
    chk(rd[STAT_DONE], 1);
    apb(1, STAT_OFS, 32'h4);
    state_is(4'd5);
    chk(rd[STAT_DONE], 0);
    @(posedge clk_i);
    bat_mv <= 16'd3000;
    wt(6);
    state_is(4'd1);
    @(posedge clk_i);
    bat_mv <= 16'd3600;
    wt(4);
    @(posedge clk_i);
    bat_mv <= 16'd3000;
    wt(14);
    state_is(4'd3);
    chk(rd[STAT_NOBAT], 1);
    apb(0, CTRL_OFS, 0);
    chk(rd, CTRL_RESET);
    // mid-run resets: supervised weak battery, then unsupervised good battery
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      rst_b_i <= 0;
      otg_pin_i <= 1;
      host_supervised_i <= (k == 0);
      bat_mv <= (k == 0) ? 16'd3000 : 16'd3600;
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1;
      wt(8);
      chk(ilim_high_o, 0);
      chk(ilim_enable_o, 1);
    end
    end_sim();
  end
endmodule
`default_nettype wire
